// file: hdl/timer16_pkg.sv
package timer16_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_COUNTER  = 16'hff12;
    localparam logic [15:0] IDX_CYCLE    = 16'hff14;
    localparam logic [15:0] IDX_DUTY     = 16'hff16;
    localparam logic [15:0] IDX_CTRL     = 16'hff18;
    localparam logic [15:0] IDX_CCCTRL   = 16'hff1a;
    localparam logic [15:0] IDX_PRESCALE = 16'hff1c;
    localparam logic [15:0] IDX_STATUS   = 16'hff1e;

    localparam logic [31:0] ADDR_COUNTER  = {14'h0000, IDX_COUNTER, 2'b00};
    localparam logic [31:0] ADDR_CYCLE    = {14'h0000, IDX_CYCLE, 2'b00};
    localparam logic [31:0] ADDR_DUTY     = {14'h0000, IDX_DUTY, 2'b00};
    localparam logic [31:0] ADDR_CTRL     = {14'h0000, IDX_CTRL, 2'b00};
    localparam logic [31:0] ADDR_CCCTRL   = {14'h0000, IDX_CCCTRL, 2'b00};
    localparam logic [31:0] ADDR_PRESCALE = {14'h0000, IDX_PRESCALE, 2'b00};
    localparam logic [31:0] ADDR_STATUS   = {14'h0000, IDX_STATUS, 2'b00};

    // ==========================================================
    // Field positions
    localparam int CTRL_ONESHOT_TRIG = 0;
    localparam int CTRL_OPMODE_LO    = 2;
    localparam int CTRL_ONESHOT_MODE = 4;
    localparam int CTRL_CYC_TOG      = 8;
    localparam int CTRL_DUTY_TOG     = 9;
    localparam int CTRL_IRQ_MASK     = 12;
    localparam int CC_CYCLE_FUNC     = 0;
    localparam int CC_DUTY_FUNC      = 1;
    localparam int PRE_CLK_LO        = 0;
    localparam int PRE_CAP_SRC       = 2;
    localparam int PRE_EDGE_A_LO     = 4;
    localparam int PRE_EDGE_B_LO     = 6;
    localparam int ST_FLAG           = 0;
    localparam int ST_OUT            = 1;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_COUNTER  = 16'h0000;
    localparam logic [15:0] RST_CC       = 16'h0000;
    localparam logic [7:0]  RST_DIV      = 8'h00;
    localparam logic        RST_IRQ_MASK = 1'b1;

    // ==========================================================
    // Timing: divided sampling ticks of the peripheral clock
    localparam logic [1:0] DIV4_LAST   = 2'h3;
    localparam logic [7:0] DIV256_LAST = 8'hff;

    // ==========================================================
    // Modes and encodings
    typedef enum logic [1:0] {
        OPM_STOP        = 2'h0,
        OPM_FREE        = 2'h1,
        OPM_CLEAR_EDGE  = 2'h2,
        OPM_CLEAR_MATCH = 2'h3
    } opmode_t;

    typedef enum logic [1:0] {
        CLK_DIV1   = 2'h0,
        CLK_DIV4   = 2'h1,
        CLK_DIV256 = 2'h2,
        CLK_EDGE_A = 2'h3
    } clksel_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_NONE = 2'h3
    } edge_t;

endpackage : timer16_pkg

// file: hdl/edge_sampler.sv
`timescale 1ns/1ps
module edge_sampler
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Sampling
    input  wire logic       sample_en,
    input  wire logic       level,
    input  wire logic [1:0] edge_sel,
    // Result
    output logic            edge_seen
);

    // ==========================================================
    // Sample register and edge pulse
    logic prev;
    logic next_prev;
    logic next_edge_seen;
    logic rise;
    logic fall;

    always_comb begin
        rise      = sample_en & level & ~prev;
        fall      = sample_en & ~level & prev;
        next_prev = sample_en ? level : prev;
        case (edge_t'(edge_sel))
            EDGE_FALL: next_edge_seen = fall;
            EDGE_RISE: next_edge_seen = rise;
            EDGE_BOTH: next_edge_seen = rise | fall;
            default:   next_edge_seen = 1'b0;
        endcase
    end

    // Prev starts low, so a high input reads as a rise at first sample
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev      <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            prev      <= next_prev;
            edge_seen <= next_edge_seen;
        end
    end

endmodule : edge_sampler

// file: hdl/timer16_capture_compare.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Read-only 16-bit counter increments on count ticks
// - Counter read defers tick; a tick during a read while one is already parked is lost
// - Reset forces counter to zero
// - Both mode bits clear stops, clears counter
// - Edge clear mode: input A edge clears
// - Match clear mode: cycle match clears counter
// - One-shot trigger write clears counter
// - Counter reads never cause any capture
// - Capture/compare control bit 0 picks capture or compare for cycle, bit 1 for duty
// - Cycle register: 16-bit write, resets zero
// - Cycle compare match raises match request
// - Cycle register sets interval timer period
// - Capture counter on selected input edge
// - Counting continues while toggling is disabled
// - Unsafe duty rewrite toggles output each time
// - Capture sampling at clk, clk/4, clk/256
module timer16_capture_compare
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pins
    input  wire logic        capture_input_a,
    input  wire logic        capture_input_b,
    output logic             timer_out_pin,
    output logic             match_irq
);

    // ==========================================================
    // State
    logic [15:0] main_counter;
    logic [15:0] cycle_capture_compare;
    logic [15:0] duty_capture_compare;
    opmode_t     opmode;
    logic        oneshot_mode;
    logic        cycle_toggle_enable;
    logic        duty_toggle_enable;
    logic        match_irq_mask;
    logic        cycle_func_capture;
    logic        duty_func_capture;
    clksel_t     clk_sel;
    logic        cap_src_b;
    logic [1:0]  edge_a_sel;
    logic [1:0]  edge_b_sel;
    logic        match_irq_flag;
    logic        pending_tick;
    logic [7:0]  div;
    logic        wr_pend;
    logic [31:0] wr_addr;

    logic [15:0] next_main_counter;
    logic [15:0] next_cycle_capture_compare;
    logic [15:0] next_duty_capture_compare;
    opmode_t     next_opmode;
    logic        next_oneshot_mode;
    logic        next_cycle_toggle_enable;
    logic        next_duty_toggle_enable;
    logic        next_match_irq_mask;
    logic        next_cycle_func_capture;
    logic        next_duty_func_capture;
    clksel_t     next_clk_sel;
    logic        next_cap_src_b;
    logic [1:0]  next_edge_a_sel;
    logic [1:0]  next_edge_b_sel;
    logic        next_match_irq_flag;
    logic        next_pending_tick;
    logic [7:0]  next_div;
    logic        next_wr_pend;
    logic [31:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic        next_timer_out_pin;
    logic        next_match_irq;

    // ==========================================================
    // Combinational helpers
    logic addr_ok;
    logic counter_read;
    logic wr_ctrl;
    logic wr_cycle;
    logic wr_duty;
    logic wr_status;
    logic div_tick;
    logic sample_en;
    logic edge_a;
    logic edge_b;
    logic cap_edge;
    logic running;
    logic tick;
    logic advance;
    logic cyc_match;
    logic duty_match;
    logic oneshot_fire;
    logic duty_rewrite_toggle;

    // ==========================================================
    // Capture input samplers
    edge_sampler u_edge_a (
        .clk       (clk),
        .rstn      (rstn),
        .sample_en (sample_en),
        .level     (capture_input_a),
        .edge_sel  (edge_a_sel),
        .edge_seen (edge_a)
    );

    edge_sampler u_edge_b (
        .clk       (clk),
        .rstn      (rstn),
        .sample_en (sample_en),
        .level     (capture_input_b),
        .edge_sel  (edge_b_sel),
        .edge_seen (edge_b)
    );

    // ==========================================================
    // Bus decode and read mux
    always_comb begin
        addr_ok      = hsel & hready & htrans[1];
        counter_read = addr_ok & ~hwrite & (haddr == ADDR_COUNTER);
        wr_ctrl      = wr_pend & (wr_addr == ADDR_CTRL);
        wr_cycle     = wr_pend & (wr_addr == ADDR_CYCLE);
        wr_duty      = wr_pend & (wr_addr == ADDR_DUTY);
        wr_status    = wr_pend & (wr_addr == ADDR_STATUS);
        next_wr_pend = addr_ok & hwrite;
        next_wr_addr = (addr_ok & hwrite) ? haddr : wr_addr;
        next_hrdata  = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr)
                ADDR_COUNTER:  next_hrdata = {16'h0000, main_counter};
                ADDR_CYCLE:    next_hrdata = {16'h0000, cycle_capture_compare};
                ADDR_DUTY:     next_hrdata = {16'h0000, duty_capture_compare};
                ADDR_CTRL:     next_hrdata = {19'h0_0000, match_irq_mask, 2'b00, duty_toggle_enable,
                                              cycle_toggle_enable, 3'b000, oneshot_mode, opmode, 2'b00};
                ADDR_CCCTRL:   next_hrdata = {30'h0000_0000, duty_func_capture, cycle_func_capture};
                ADDR_PRESCALE: next_hrdata = {24'h00_0000, edge_b_sel, edge_a_sel, 1'b0, cap_src_b, clk_sel};
                ADDR_STATUS:   next_hrdata = {30'h0000_0000, timer_out_pin, match_irq_flag};
                default:       next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Configuration registers, written in the data phase
    always_comb begin
        next_opmode              = opmode;
        next_oneshot_mode        = oneshot_mode;
        next_cycle_toggle_enable = cycle_toggle_enable;
        next_duty_toggle_enable  = duty_toggle_enable;
        next_match_irq_mask      = match_irq_mask;
        next_cycle_func_capture  = cycle_func_capture;
        next_duty_func_capture   = duty_func_capture;
        next_clk_sel             = clk_sel;
        next_cap_src_b           = cap_src_b;
        next_edge_a_sel          = edge_a_sel;
        next_edge_b_sel          = edge_b_sel;
        if (wr_ctrl) begin
            next_opmode              = opmode_t'(hwdata[CTRL_OPMODE_LO +: 2]);
            next_oneshot_mode        = hwdata[CTRL_ONESHOT_MODE];
            next_cycle_toggle_enable = hwdata[CTRL_CYC_TOG];
            next_duty_toggle_enable  = hwdata[CTRL_DUTY_TOG];
            next_match_irq_mask      = hwdata[CTRL_IRQ_MASK];
        end
        if (wr_pend && wr_addr == ADDR_CCCTRL) begin
            next_cycle_func_capture = hwdata[CC_CYCLE_FUNC];
            next_duty_func_capture  = hwdata[CC_DUTY_FUNC];
        end
        if (wr_pend && wr_addr == ADDR_PRESCALE) begin
            next_clk_sel    = clksel_t'(hwdata[PRE_CLK_LO +: 2]);
            next_cap_src_b  = hwdata[PRE_CAP_SRC];
            next_edge_a_sel = hwdata[PRE_EDGE_A_LO +: 2];
            next_edge_b_sel = hwdata[PRE_EDGE_B_LO +: 2];
        end
    end

    // ==========================================================
    // Count clock, sampling clock and the counter
    always_comb begin
        next_div = div + 8'h01;
        case (clk_sel)
            CLK_DIV1:   div_tick = 1'b1;
            CLK_DIV4:   div_tick = (div[1:0] == DIV4_LAST);
            CLK_DIV256: div_tick = (div == DIV256_LAST);
            default:    div_tick = 1'b0;
        endcase
        // Edge-counted mode samples at the full rate
        sample_en = (clk_sel == CLK_EDGE_A) ? 1'b1 : div_tick;
        running   = (opmode != OPM_STOP);
        tick      = running & ((clk_sel == CLK_EDGE_A) ? edge_a : div_tick);
        // Read cycle parks the tick for replay; a tick in a read while one is already parked is dropped
        advance   = ~counter_read & (tick | pending_tick);
        if (!running) begin
            next_pending_tick = 1'b0;
        end else if (counter_read) begin
            next_pending_tick = pending_tick | tick;
        end else begin
            next_pending_tick = tick & pending_tick;
        end
        cyc_match  = advance & ~cycle_func_capture & (main_counter == cycle_capture_compare);
        duty_match = advance & ~duty_func_capture & (main_counter == duty_capture_compare);
        oneshot_fire = wr_ctrl & hwdata[CTRL_ONESHOT_TRIG] & oneshot_mode & running;
        if (!running) begin
            next_main_counter = RST_COUNTER;
        end else if (oneshot_fire) begin
            next_main_counter = RST_COUNTER;
        end else if (opmode == OPM_CLEAR_EDGE && edge_a) begin
            next_main_counter = RST_COUNTER;
        end else if (opmode == OPM_CLEAR_MATCH && cyc_match) begin
            next_main_counter = RST_COUNTER;
        end else if (advance) begin
            next_main_counter = main_counter + 16'h0001;
        end else begin
            next_main_counter = main_counter;
        end
    end

    // ==========================================================
    // Capture/compare registers
    always_comb begin
        cap_edge                   = cap_src_b ? edge_b : edge_a;
        next_cycle_capture_compare = cycle_capture_compare;
        next_duty_capture_compare  = duty_capture_compare;
        // Capture beats a colliding write: the event is not lost
        if (cycle_func_capture && cap_edge) begin
            next_cycle_capture_compare = main_counter;
        end else if (wr_cycle) begin
            next_cycle_capture_compare = hwdata[15:0];
        end
        if (duty_func_capture && edge_a) begin
            next_duty_capture_compare = main_counter;
        end else if (wr_duty) begin
            next_duty_capture_compare = hwdata[15:0];
        end
    end

    // ==========================================================
    // Output pin, match flag and request
    always_comb begin
        // Unguarded duty rewrite while counting flips the pin per write
        duty_rewrite_toggle = wr_duty & running & duty_toggle_enable & ~duty_func_capture;
        next_timer_out_pin  = timer_out_pin ^ (cyc_match & cycle_toggle_enable)
                              ^ (duty_match & duty_toggle_enable) ^ duty_rewrite_toggle;
        // Set wins over a clear in the same cycle
        next_match_irq_flag = cyc_match | (match_irq_flag & ~(wr_status & hwdata[ST_FLAG]));
        next_match_irq      = next_match_irq_flag & ~next_match_irq_mask;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_counter          <= RST_COUNTER;
            cycle_capture_compare <= RST_CC;
            duty_capture_compare  <= RST_CC;
            opmode                <= OPM_STOP;
            oneshot_mode          <= 1'b0;
            cycle_toggle_enable   <= 1'b0;
            duty_toggle_enable    <= 1'b0;
            match_irq_mask        <= RST_IRQ_MASK;
            cycle_func_capture    <= 1'b0;
            duty_func_capture     <= 1'b0;
            clk_sel               <= CLK_DIV1;
            cap_src_b             <= 1'b0;
            edge_a_sel            <= EDGE_FALL;
            edge_b_sel            <= EDGE_FALL;
            match_irq_flag        <= 1'b0;
            pending_tick          <= 1'b0;
            div                   <= RST_DIV;
            wr_pend               <= 1'b0;
            wr_addr               <= 32'h0000_0000;
            hrdata                <= 32'h0000_0000;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
            timer_out_pin         <= 1'b0;
            match_irq             <= 1'b0;
        end else begin
            main_counter          <= next_main_counter;
            cycle_capture_compare <= next_cycle_capture_compare;
            duty_capture_compare  <= next_duty_capture_compare;
            opmode                <= next_opmode;
            oneshot_mode          <= next_oneshot_mode;
            cycle_toggle_enable   <= next_cycle_toggle_enable;
            duty_toggle_enable    <= next_duty_toggle_enable;
            match_irq_mask        <= next_match_irq_mask;
            cycle_func_capture    <= next_cycle_func_capture;
            duty_func_capture     <= next_duty_func_capture;
            clk_sel               <= next_clk_sel;
            cap_src_b             <= next_cap_src_b;
            edge_a_sel            <= next_edge_a_sel;
            edge_b_sel            <= next_edge_b_sel;
            match_irq_flag        <= next_match_irq_flag;
            pending_tick          <= next_pending_tick;
            div                   <= next_div;
            wr_pend               <= next_wr_pend;
            wr_addr               <= next_wr_addr;
            hrdata                <= next_hrdata;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
            timer_out_pin         <= next_timer_out_pin;
            match_irq             <= next_match_irq;
        end
    end

    // hsize is not decoded: every access is treated as a full word
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule : timer16_capture_compare

// file: verif/timer16_capture_compare_monitor.sv
`timescale 1ns/1ps
module timer16_capture_compare_monitor
    import timer16_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic        timer_out_pin,
    input wire logic        match_irq
);
    logic        a_rd;
    logic        a_wr;
    logic [31:0] a_addr;
    logic [15:0] cyc;
    logic        msk;
    logic        ctog;
    logic        dtog;
    logic        ever_cap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Write shadow, in step with the design
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            a_rd     <= 1'b0;
            a_wr     <= 1'b0;
            a_addr   <= 32'h0000_0000;
            cyc      <= RST_CC;
            msk      <= RST_IRQ_MASK;
            ctog     <= 1'b0;
            dtog     <= 1'b0;
            ever_cap <= 1'b0;
        end else begin
            a_rd   <= hsel && hready && htrans[1] && !hwrite;
            a_wr   <= hsel && hready && htrans[1] && hwrite;
            a_addr <= haddr;
            if (a_wr && a_addr == ADDR_CYCLE) cyc <= hwdata[15:0];
            // Captures are unseen here; readback check ends with capture use
            if (a_wr && a_addr == ADDR_CCCTRL && hwdata[CC_CYCLE_FUNC]) ever_cap <= 1'b1;
            if (a_wr && a_addr == ADDR_CTRL) begin
                msk  <= hwdata[CTRL_IRQ_MASK];
                ctog <= hwdata[CTRL_CYC_TOG];
                dtog <= hwdata[CTRL_DUTY_TOG];
            end
        end
    end
    // ==========================================================
    // Properties
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error");
    property p_reset_quiet; $rose(rstn) |-> !timer_out_pin && !match_irq; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_cnt_ro; a_rd && a_addr == ADDR_COUNTER |-> hrdata[31:16] == 16'h0000; endproperty
    a_cnt_ro: assert property (p_cnt_ro) else $error("counter wider than 16 bits");
    property p_cyc_back; a_rd && a_addr == ADDR_CYCLE && !ever_cap |-> hrdata == {16'h0000, cyc}; endproperty
    a_cyc_back: assert property (p_cyc_back) else $error("cycle register readback wrong");
    property p_irq_mask; msk && $past(msk) |-> !match_irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked match request seen");
    property p_pin_hold; !ctog && !dtog && !$past(ctog) && !$past(dtog) |-> $stable(timer_out_pin); endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved with toggling off");
    property p_stat_pin; a_rd && a_addr == ADDR_STATUS |-> hrdata[ST_OUT] == $past(timer_out_pin); endproperty
    a_stat_pin: assert property (p_stat_pin) else $error("status pin level wrong");
    property p_ctrl_read; a_rd && a_addr == ADDR_CTRL |-> !hrdata[0] && hrdata[CTRL_IRQ_MASK] == msk; endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
endmodule : timer16_capture_compare_monitor

bind timer16_capture_compare timer16_capture_compare_monitor mon (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_out_pin(timer_out_pin), .match_irq(match_irq)
);

// file: verif/edge_source.sv
`timescale 1ns/1ps
module edge_source (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Timer side
    input  wire logic timer_out_pin,
    output logic      capture_input_a,
    output logic      capture_input_b
);
    int   flips;
    logic last_pin;
    initial begin
        capture_input_a = 1'b0;
        capture_input_b = 1'b0;
        flips = 0;
    end
    // ==========================================================
    // Counts inversions seen on the output pin
    always @(posedge clk) begin
        if (rstn && timer_out_pin !== last_pin) flips++;
        last_pin <= timer_out_pin;
    end
    // Levels held several samples so each is a valid edge; gap sets the pace
    task automatic toggle_a(input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            capture_input_a <= !capture_input_a;
            repeat (gap) @(posedge clk);
        end
    endtask : toggle_a
    task automatic set_b(input logic v);
        @(posedge clk);
        capture_input_b <= v;
    endtask : set_b
endmodule : edge_source

// file: verif/tb_timer16_capture_compare.sv
`timescale 1ns/1ps
module tb_timer16_capture_compare
    import timer16_pkg::*;
;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        clk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        cap_a;
    logic        cap_b;
    logic        pin;
    logic        irq;
    logic        rd_dp;
    logic [63:0] notes[$];
    logic [63:0] nt;
    logic [31:0] r;
    int          fail_count;
    int          n_compared;
    int          n;
    int          f0;
    timer16_capture_compare dut (
        .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .capture_input_a(cap_a), .capture_input_b(cap_b), .timer_out_pin(pin),
        .match_irq(irq)
    );
    edge_source ptn (.clk(clk), .rstn(rstn), .timer_out_pin(pin), .capture_input_a(cap_a),
        .capture_input_b(cap_b));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // Checking and bus tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic wait_rdy;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) return;
        end
        fail_count++;
        end_of_test;
    endtask : wait_rdy
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    // Mask keeps only the bits that are certain
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
        notes.push_back({m, exp});
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    always @(posedge clk) begin
        if (rd_dp && notes.size() > 0) begin
            nt = notes.pop_front();
            check("hrdata", hrdata & nt[63:32], nt[31:0] & nt[63:32]);
        end
        rd_dp <= rstn && hsel && hreadyout && htrans[1] && !hwrite;
    end
    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        rd_dp = 1'b0;
        fail_count = 0;
        n_compared = 0;
        void'($urandom(32'h9439));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        rd(ADDR_CYCLE, 32'h0000_0000, ALL);
        rd(ADDR_CTRL, 32'h0000_1000, ALL);
        rd(ADDR_STATUS, 32'h0000_0000, ALL);
        rd(32'h0000_0100, 32'h0000_0000, ALL);
        done("reset");
        r = $urandom;
        wr(ADDR_CYCLE, r);
        rd(ADDR_CYCLE, {16'h0000, r[15:0]}, ALL);
        wr(ADDR_COUNTER, r);
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        wr(ADDR_DUTY, 32'h0000_0a5c);
        done("registers");
        wr(ADDR_PRESCALE, 32'h0000_0067);
        wr(ADDR_CCCTRL, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_1004);
        n = $urandom_range(8, 3);
        fork
            ptn.toggle_a(n, 2);
            repeat (n) rd(ADDR_COUNTER, 32'h0000_0000, 32'hffff_0000);
        join
        repeat (6) @(posedge clk);
        rd(ADDR_COUNTER, 32'(n), ALL);
        rd(ADDR_CYCLE, {16'h0000, r[15:0]}, ALL);
        ptn.set_b(1'b1);
        repeat (6) @(posedge clk);
        rd(ADDR_CYCLE, 32'(n), ALL);
        ptn.set_b(1'b0);
        done("count and capture");
        wr(ADDR_CTRL, 32'h0000_1008);
        rd(ADDR_COUNTER, 32'(n), ALL);
        ptn.toggle_a(1, 6);
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        done("edge clear");
        wr(ADDR_CCCTRL, 32'h0000_0000);
        wr(ADDR_CYCLE, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_010c);
        ptn.toggle_a(3, 3);
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        rd(ADDR_STATUS, 32'h0000_0003, ALL);
        check("match_irq", {31'h0, irq}, 32'h0000_0001);
        check("pin flips", 32'(ptn.flips), 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("match_irq", {31'h0, irq}, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0002, ALL);
        ptn.toggle_a(1, 3);
        wr(ADDR_CTRL, 32'h0000_1000);
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        done("match and stop");
        wr(ADDR_CTRL, 32'h0000_1014);
        ptn.toggle_a(2, 3);
        rd(ADDR_COUNTER, 32'h0000_0002, ALL);
        wr(ADDR_CTRL, 32'h0000_1015);
        rd(ADDR_COUNTER, 32'h0000_0000, ALL);
        rd(ADDR_CTRL, 32'h0000_1014, ALL);
        done("one-shot");
        wr(ADDR_CTRL, 32'h0000_1204);
        f0 = ptn.flips;
        wr(ADDR_DUTY, 32'h0000_7777);
        wr(ADDR_DUTY, 32'h0000_7778);
        repeat (3) @(posedge clk);
        check("pin flips", 32'(ptn.flips), 32'(f0 + 2));
        rd(ADDR_DUTY, 32'h0000_7778, ALL);
        wr(ADDR_CTRL, 32'h0000_1004);
        wr(ADDR_DUTY, 32'h0000_1111);
        repeat (3) @(posedge clk);
        check("pin flips", 32'(ptn.flips), 32'(f0 + 2));
        done("duty rewrite");
        end_of_test;
    end
endmodule : tb_timer16_capture_compare
